// ### swr_cpu_model.sv
module swr_cpu_model (
    input  wire logic        ref_clk,       // Clock
    input  wire logic        reset_n,       // Reset from supervisor
    input  wire logic [15:0] kick_period,   // Cycles per kick, 0 stalls
    output logic             watchdog_kick  // Kick level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt;
    initial begin
        watchdog_kick = 1'b0;
        cnt = 16'h0000;
    end
    // Processor reboots while in reset, then services at its own pace
    always @(negedge ref_clk) begin
        if (!reset_n || kick_period == 16'h0000) begin
            cnt <= 16'h0000;
        end else if (cnt + 16'h0001 >= kick_period) begin
            cnt <= 16'h0000;
            watchdog_kick <= !watchdog_kick;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule // swr_cpu_model

// ### swr_pkg.sv
package swr_pkg;

    // Internal oscillator, nominal 10.24 kHz
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned OSC_MHZ_X100    = 1024;
    localparam int unsigned OSC_HZ          = OSC_MHZ_X100 * 10;
    localparam int unsigned OSC_HALF_CYC    = CLK_HZ / (2 * OSC_HZ);

    // Times in ms, as printed
    localparam int unsigned RST_DELAY_MS    = 50;
    localparam int unsigned WD_LONG_MS      = 1600;
    localparam int unsigned WD_FAST_MS      = 100;

    // Oscillator-tick counts derived from the times
    localparam int unsigned RST_TICKS_INT   = RST_DELAY_MS * OSC_HZ / 1000;
    localparam int unsigned WD_LONG_TICKS   = WD_LONG_MS * OSC_HZ / 1000;
    localparam int unsigned WD_FAST_TICKS   = WD_FAST_MS * OSC_HZ / 1000;

    // External clock counts
    localparam int unsigned RST_TICKS_EXT   = 512;
    localparam int unsigned WD_NORM_EXT     = 1024;
    localparam int unsigned WD_LONG_EXT     = 4096;

    localparam int unsigned CNT_W           = 16;

    typedef enum logic [1:0] {
        SWR_RUN   = 2'b00,
        SWR_HOLD  = 2'b01,
        SWR_PULSE = 2'b10
    } swr_state_type;

    typedef struct packed {
        logic low_line_sense;    // High: supply above threshold
        logic power_fail_sense;  // High: input above reference
        logic below_backup;      // High: supply below backup supply
        logic kick_float;        // High: kick pin floating or mid level
        logic watchdog_kick;
        logic ce_in_n;
        logic timing_source_select;
        logic timing_source_in;
    } swr_pins_type;

    typedef struct packed {
        logic reset_n;
        logic reset;
        logic power_fail_flag_n;
        logic watchdog_expired_n;
        logic ce_out_n;
        logic backup_active;
    } swr_outs_type;

endpackage : swr_pkg

// ### swr_supervisor.sv
// Summary of operation
// - Reset low while low-line reports low supply
// - Hold reset 50 ms after supply recovers
// - Active-high reset is inverse of reset
// - Power-fail flag follows power-fail comparator
// - Below backup forces power-fail flag low
// - Kick timeout issues a 50 ms reset pulse
// - Repeat reset pulse every timeout period
// - Expiry flag low until kick outside reset
// - Floating kick disables watchdog, flag high
// - Longer timeout applies right after reset
// - Good supply passes chip enable through
// - Low supply forces chip enable high
// - Below backup forces chip enable high
// - Backup active when supply below backup
// - Constant kick beyond timeout pulls reset
// - Restart timer at reset end, ignore kicks
// - Normal timeout after first post-reset kick
// - Low supply sets expiry flag high
// - Timing from 10.24 kHz oscillator ticks or external clock edges
module swr_supervisor
    import swr_pkg::*;
#(
    parameter int unsigned RST_TICKS  = RST_TICKS_INT,
    parameter int unsigned WD_LONG    = WD_LONG_TICKS,
    parameter int unsigned WD_FAST    = WD_FAST_TICKS,
    parameter int unsigned E_RST      = RST_TICKS_EXT,
    parameter int unsigned E_NORM     = WD_NORM_EXT,
    parameter int unsigned E_LONG     = WD_LONG_EXT,
    parameter int unsigned HALF_CYC   = OSC_HALF_CYC
) (
    input  wire logic ref_clk,              // 20 MHz clock
    input  wire logic resetn,               // Sync reset, active low
    input  wire logic low_line_sense,       // High: supply above threshold
    input  wire logic power_fail_sense,     // High: above reference
    input  wire logic below_backup,         // High: supply below backup
    input  wire logic kick_float,           // High: kick floating/mid
    input  wire logic watchdog_kick,        // Kick from processor
    input  wire logic ce_in_n,              // Chip enable in, active low
    input  wire logic timing_source_select, // High: internal oscillator
    input  wire logic timing_source_in,     // Ext clock / fast select
    output logic      reset_n,              // Reset, active low
    output logic      reset,                // Reset, active high
    output logic      power_fail_flag_n,    // Power-fail flag, active low
    output logic      watchdog_expired_n,   // Expiry flag, active low
    output logic      ce_out_n,             // Gated chip enable
    output logic      backup_active         // Backup supply selected
);

    swr_pins_type pins_raw;
    swr_pins_type pins;

    assign pins_raw = '{low_line_sense:       low_line_sense,
                        power_fail_sense:     power_fail_sense,
                        below_backup:         below_backup,
                        kick_float:           kick_float,
                        watchdog_kick:        watchdog_kick,
                        ce_in_n:              ce_in_n,
                        timing_source_select: timing_source_select,
                        timing_source_in:     timing_source_in};

    swr_sync #(
        .WIDTH ($bits(swr_pins_type))
    ) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    function automatic logic [CNT_W-1:0] cnt_of(input int unsigned v);
        return CNT_W'(v);
    endfunction

    // Tick generation: internal divider or external clock edges
    logic [CNT_W-1:0] div_q, div_d;
    logic             osc_q, osc_d;
    logic             ext_prev_q, ext_prev_d;
    logic             tick;
    logic             ext_mode;

    assign ext_mode = !pins.timing_source_select;

    always_comb begin
        div_d      = div_q + 1'b1;
        osc_d      = osc_q;
        ext_prev_d = pins.timing_source_in;
        tick       = 1'b0;
        if (div_q >= cnt_of(HALF_CYC) - 1'b1) begin
            div_d = '0;
            osc_d = !osc_q;
            tick  = !osc_q;
        end
        if (ext_mode) begin
            tick = pins.timing_source_in && !ext_prev_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            div_q      <= '0;
            osc_q      <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            div_q      <= div_d;
            osc_q      <= osc_d;
            ext_prev_q <= ext_prev_d;
        end
    end

    // Period selection
    logic [CNT_W-1:0] rst_len;
    logic [CNT_W-1:0] wd_long;
    logic [CNT_W-1:0] wd_norm;

    always_comb begin
        if (ext_mode) begin
            rst_len = cnt_of(E_RST);
            wd_long = cnt_of(E_LONG);
            wd_norm = cnt_of(E_NORM);
        end else begin
            rst_len = cnt_of(RST_TICKS);
            wd_long = cnt_of(WD_LONG);
            wd_norm = pins.timing_source_in ? cnt_of(WD_LONG)
                                            : cnt_of(WD_FAST);
        end
    end

    // Reset and watchdog state
    swr_state_type    st_q, st_d;
    logic [CNT_W-1:0] rcnt_q, rcnt_d;
    logic [CNT_W-1:0] wcnt_q, wcnt_d;
    logic             long_q, long_d;
    logic             kick_prev_q, kick_prev_d;
    logic             wdo_n_q, wdo_n_d;
    logic             rst_n_q, rst_n_d;
    logic             rst_q, rst_d;
    logic             pfo_n_q, pfo_n_d;
    logic             ce_q, ce_d;
    logic             bat_q, bat_d;
    logic             supply_low;
    logic             kick_edge;
    logic             wd_en;

    assign supply_low = !pins.low_line_sense || pins.below_backup;
    assign kick_edge  = pins.watchdog_kick != kick_prev_q;
    assign wd_en      = !pins.kick_float;

    always_comb begin
        st_d        = st_q;
        rcnt_d      = rcnt_q;
        wcnt_d      = wcnt_q;
        long_d      = long_q;
        kick_prev_d = pins.watchdog_kick;
        wdo_n_d     = wdo_n_q;
        unique case (st_q)
            SWR_HOLD: begin
                if (supply_low) begin
                    rcnt_d = '0;
                end else if (tick) begin
                    if (rcnt_q >= rst_len - 1'b1) begin
                        st_d   = SWR_RUN;
                        wcnt_d = '0;
                        long_d = 1'b1;
                    end else begin
                        rcnt_d = rcnt_q + 1'b1;
                    end
                end
            end
            SWR_PULSE: begin
                if (tick) begin
                    if (rcnt_q >= rst_len - 1'b1) begin
                        st_d   = SWR_RUN;
                        wcnt_d = '0;
                        long_d = 1'b1;
                    end else begin
                        rcnt_d = rcnt_q + 1'b1;
                    end
                end
            end
            SWR_RUN: begin
                if (!wd_en) begin
                    wcnt_d  = '0;
                    wdo_n_d = 1'b1;
                end else if (kick_edge) begin
                    wcnt_d  = '0;
                    long_d  = 1'b0;
                    wdo_n_d = 1'b1;
                end else if (tick) begin
                    if (wcnt_q >= (long_q ? wd_long : wd_norm) - 1'b1) begin
                        st_d    = SWR_PULSE;
                        rcnt_d  = '0;
                        wdo_n_d = 1'b0;
                    end else begin
                        wcnt_d = wcnt_q + 1'b1;
                    end
                end
            end
            default: begin
                st_d = SWR_HOLD;
            end
        endcase
        if (!wd_en) begin
            wdo_n_d = 1'b1;
        end
        if (supply_low) begin
            st_d    = SWR_HOLD;
            rcnt_d  = '0;
            wdo_n_d = 1'b1;
        end
        rst_n_d = (st_d == SWR_RUN);
        rst_d   = !rst_n_d;
        pfo_n_d = pins.power_fail_sense && !pins.below_backup;
        ce_d    = pins.ce_in_n || supply_low;
        bat_d   = pins.below_backup;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_q        <= SWR_HOLD;
            rcnt_q      <= '0;
            wcnt_q      <= '0;
            long_q      <= 1'b1;
            kick_prev_q <= 1'b0;
            wdo_n_q     <= 1'b1;
            rst_n_q     <= 1'b0;
            rst_q       <= 1'b1;
            pfo_n_q     <= 1'b0;
            ce_q        <= 1'b1;
            bat_q       <= 1'b0;
        end else begin
            st_q        <= st_d;
            rcnt_q      <= rcnt_d;
            wcnt_q      <= wcnt_d;
            long_q      <= long_d;
            kick_prev_q <= kick_prev_d;
            wdo_n_q     <= wdo_n_d;
            rst_n_q     <= rst_n_d;
            rst_q       <= rst_d;
            pfo_n_q     <= pfo_n_d;
            ce_q        <= ce_d;
            bat_q       <= bat_d;
        end
    end

    assign reset_n            = rst_n_q;
    assign reset              = rst_q;
    assign power_fail_flag_n  = pfo_n_q;
    assign watchdog_expired_n = wdo_n_q;
    assign ce_out_n           = ce_q;
    assign backup_active      = bat_q;

endmodule // swr_supervisor

// ### swr_supervisor_asserts.sv
module swr_asserts #(
    parameter int unsigned RST_TICKS = 4,
    parameter int unsigned HALF_CYC  = 2
) (
    input wire logic ref_clk,            // Clock
    input wire logic resetn,             // Reset
    input wire logic low_line_sense,     // Supply good
    input wire logic power_fail_sense,   // Above reference
    input wire logic below_backup,       // Below backup
    input wire logic kick_float,         // Kick floating
    input wire logic ce_in_n,            // Enable in
    input wire logic reset_n,            // Reset out
    input wire logic reset,              // Reset out, high
    input wire logic power_fail_flag_n,  // Power-fail flag
    input wire logic watchdog_expired_n, // Expiry flag
    input wire logic ce_out_n,           // Gated enable
    input wire logic backup_active       // Backup selected
);
    localparam int unsigned P = 2 * HALF_CYC;
    logic [15:0] low_q;
    logic [15:0] low_d;
    logic        good;
    assign good = low_line_sense && !below_backup;
    // Cycles of reset held while supply is good
    always_comb begin
        low_d = (reset_n || !good) ? 16'h0000 : low_q + 16'h0001;
    end
    always_ff @(posedge ref_clk) begin
        low_q <= resetn ? low_d : 16'h0000;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_reset_inverse: assert property (
        reset == !reset_n) else $error("Reset outputs not inverse");
    a_lowline_reset: assert property (
        (!low_line_sense)[*4] |-> !reset_n) else $error("Reset not held");
    a_delay_min: assert property (
        $rose(reset_n) |-> low_q >= 16'((RST_TICKS - 1) * P))
        else $error("Reset released early");
    a_pulse_max: assert property (
        low_q <= 16'((RST_TICKS + 1) * P + 6)) else $error("Reset too long");
    a_wd_expiry: assert property (
        good[*5] ##0 $fell(reset_n) |-> !watchdog_expired_n)
        else $error("Expiry flag missing");
    a_ce_pass: assert property (
        (good && $stable(ce_in_n))[*5] |-> ce_out_n == ce_in_n)
        else $error("Enable not passed");
    a_ce_forced: assert property (
        (!good)[*4] |-> ce_out_n) else $error("Enable not blocked");
    a_pfo_follow: assert property (
        (!below_backup && $stable(power_fail_sense))[*5]
        |-> power_fail_flag_n == power_fail_sense)
        else $error("Power-fail flag wrong");
    a_backup_state: assert property (
        below_backup[*4] |-> !power_fail_flag_n && backup_active)
        else $error("Backup state wrong");
    a_wdo_high: assert property (
        (kick_float || !low_line_sense)[*5] |-> watchdog_expired_n)
        else $error("Expiry flag low");
endmodule // swr_asserts

bind swr_supervisor swr_asserts #(.RST_TICKS(RST_TICKS), .HALF_CYC(HALF_CYC))
    u_chk (.ref_clk, .resetn, .low_line_sense, .power_fail_sense,
    .below_backup, .kick_float, .ce_in_n, .reset_n, .reset,
    .power_fail_flag_n, .watchdog_expired_n, .ce_out_n, .backup_active);

// ### swr_supervisor_tb.sv
module swr_supervisor_tb
    import swr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk;
    logic              resetn;
    logic              ext_on;
    logic              tsi_lvl;
    logic [3:0]        dv;
    logic [15:0]       period;
    swr_pins_type      p;
    wire swr_outs_type o;
    wire               kick;
    wire               tsi;
    int                fail_count;
    int                tests_run;
    int                n;
    int                lo;
    // External clock has a period of four system cycles
    assign tsi = ext_on ? dv[1] : tsi_lvl;
    // External-clock watchdog periods keep their documented defaults
    swr_supervisor #(.RST_TICKS(4), .WD_LONG(16), .WD_FAST(8), .E_RST(4),
        .HALF_CYC(2)) dut (
        .ref_clk(clk), .resetn(resetn), .low_line_sense(p.low_line_sense),
        .power_fail_sense(p.power_fail_sense), .below_backup(p.below_backup),
        .kick_float(p.kick_float), .watchdog_kick(kick), .ce_in_n(p.ce_in_n),
        .timing_source_select(p.timing_source_select),
        .timing_source_in(tsi), .reset_n(o.reset_n), .reset(o.reset),
        .power_fail_flag_n(o.power_fail_flag_n),
        .watchdog_expired_n(o.watchdog_expired_n),
        .ce_out_n(o.ce_out_n), .backup_active(o.backup_active));
    swr_cpu_model cpu (.ref_clk(clk), .reset_n(o.reset_n),
        .kick_period(period), .watchdog_kick(kick));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) dv <= dv + 4'h1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_rn(input logic v, input int lim);
        n = 0;
        while (o.reset_n !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic watch(input int k);
        lo = 0;
        repeat (k) begin
            @(negedge clk);
            if (o.reset_n !== 1'b1) lo++;
        end
    endtask
    task automatic dip();
        p.low_line_sense = 1'b0;
        cyc(5);
        p.low_line_sense = 1'b1;
        wait_rn(1'b1, 40);
    endtask
    task automatic t_supply();
        p.low_line_sense = 1'b0;
        cyc(5);
        check({o.reset_n, o.reset, o.watchdog_expired_n, o.ce_out_n},
            8'h07);
        p.low_line_sense = 1'b1;
        cyc(8);
        p.low_line_sense = 1'b0;
        cyc(4);
        p.low_line_sense = 1'b1;
        cyc(12);
        check(o.reset_n, 8'h00);
        wait_rn(1'b1, 40);
    endtask
    task automatic t_pfo_ce();
        for (int i = 0; i < 8; i++) begin
            p.below_backup = i[2];
            p.power_fail_sense = i[1];
            p.ce_in_n = i[0];
            cyc(5);
            check({o.power_fail_flag_n, o.backup_active, o.ce_out_n},
                {i[1] & !i[2], i[2], i[0] | i[2]});
        end
        p.below_backup = 1'b0;
        wait_rn(1'b1, 40);
    endtask
    task automatic t_wd();
        period = 16'h0000;
        wait_rn(1'b0, 200);
        check(8'(n >= 56 && n <= 76), 8'h01);
        cyc(2);
        check(o.watchdog_expired_n, 8'h00);
        wait_rn(1'b1, 40);
        check(8'(n >= 10 && n <= 22), 8'h01);
        check(o.watchdog_expired_n, 8'h00);
        wait_rn(1'b0, 200);
        check(8'(n >= 56 && n <= 76), 8'h01);
        period = 16'h000a;
        wait_rn(1'b1, 40);
        cyc(20);
        check(o.watchdog_expired_n, 8'h01);
    endtask
    task automatic t_fast();
        dip();
        tsi_lvl = 1'b0;
        period = 16'h0030;
        wait_rn(1'b0, 200);
        check(8'(n >= 72 && n <= 96), 8'h01);
        wait_rn(1'b1, 40);
        tsi_lvl = 1'b1;
        watch(400);
        check(8'(lo), 8'h00);
    endtask
    task automatic t_float();
        period = 16'h0000;
        wait_rn(1'b0, 200);
        wait_rn(1'b1, 40);
        p.kick_float = 1'b1;
        cyc(6);
        check(o.watchdog_expired_n, 8'h01);
        watch(300);
        check(8'(lo), 8'h00);
        p.kick_float = 1'b0;
    endtask
    task automatic t_ext();
        p.timing_source_select = 1'b0;
        ext_on = 1'b1;
        dip();
        wait_rn(1'b0, 17000);
        check(8'(n >= WD_LONG_EXT * 4 - 8 && n <= WD_LONG_EXT * 4 + 12),
            8'h01);
        wait_rn(1'b1, 40);
        check(8'(n >= 10 && n <= 22), 8'h01);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        fail_count = 0;
        tests_run = 0;
        resetn = 1'b0;
        ext_on = 1'b0;
        tsi_lvl = 1'b1;
        dv = 4'h0;
        period = 16'h0014;
        p = '0;
        p.low_line_sense = 1'b1;
        p.timing_source_select = 1'b1;
        cyc(10);
        resetn = 1'b1;
        wait_rn(1'b1, 40);
        t_supply();
        t_pfo_ce();
        t_wd();
        t_fast();
        t_float();
        t_ext();
        tally_and_finish();
    end
endmodule // swr_supervisor_tb

// ### swr_sync.sv
module swr_sync
    import swr_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             resetn,   // Sync reset, active low
    input  wire logic [WIDTH-1:0] async_in, // Pin levels
    output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // swr_sync
